//--- rtl/dpr_defines.svh
`ifndef DPR_DEFINES_SVH
`define DPR_DEFINES_SVH

// ----------------------------------------
// storage geometry
// ----------------------------------------
`define DPR_DATA_BITS 16384
`define DPR_PAR_BITS 2048
`define DPR_HALF_DATA 8192
`define DPR_PAR_RATIO 8
`define DPR_NARROW_MAX 18

// ----------------------------------------
// port field widths
// ----------------------------------------
`define DPR_PORT_W 36
`define DPR_ADDR_W 14
`define DPR_BE_W 4
`define DPR_MAX_DBITS 32

`endif

//--- rtl/dpr_pkg.sv
`include "dpr_defines.svh"

package dpr_pkg;

  // ----------------------------------------
  // configuration enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    DPR_READ_FIRST,
    DPR_WRITE_FIRST,
    DPR_NO_CHANGE
  } dpr_wmode_t;

  typedef enum logic [1:0] {
    DPR_TDP18,
    DPR_TDP9,
    DPR_SDP9
  } dpr_mode_t;

  // ----------------------------------------
  // port request and module state
  // ----------------------------------------
  typedef struct packed {
    logic en;
    logic we;
    logic [`DPR_BE_W-1:0] be;
    logic [`DPR_ADDR_W-1:0] addr;
    logic [`DPR_PORT_W-1:0] din;
  } dpr_req_t;

  typedef struct packed {
    dpr_req_t [1:0] req;
    logic [1:0][`DPR_PORT_W-1:0] lat;
    logic [1:0][`DPR_PORT_W-1:0] out;
  } dpr_state_t;

endpackage

//--- rtl/dpr_block_ram.sv
`timescale 1ns/1ps
`include "dpr_defines.svh"
module dpr_block_ram #(
  parameter dpr_pkg::dpr_mode_t MODE = dpr_pkg::DPR_TDP18,
  parameter int HALF = 0,
  parameter int A_WIDTH = 36,
  parameter int B_WIDTH = 36,
  parameter dpr_pkg::dpr_wmode_t A_WMODE = dpr_pkg::DPR_READ_FIRST,
  parameter dpr_pkg::dpr_wmode_t B_WMODE = dpr_pkg::DPR_READ_FIRST,
  parameter bit A_OUT_REG = 1'b0,
  parameter bit B_OUT_REG = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // port a
  input wire dpr_pkg::dpr_req_t req_a,
  output logic [`DPR_PORT_W-1:0] dout_a,
  // port b
  input wire dpr_pkg::dpr_req_t req_b,
  output logic [`DPR_PORT_W-1:0] dout_b
);

  // ----------------------------------------
  // geometry per port
  // ----------------------------------------
  function automatic bit has_par(input int w);
    return (w == 9) || (w == 18) || (w == 36);
  endfunction

  function automatic int dbits(input int w);
    return has_par(w) ? (w / 9) * 8 : w;
  endfunction

  function automatic int pbits(input int w);
    return has_par(w) ? w / 9 : 0;
  endfunction

  function automatic bit legal_w(input int w);
    return w inside {1, 2, 4, 8, 9, 16, 18, 32, 36};
  endfunction

  localparam bit FULL = (MODE == dpr_pkg::DPR_TDP18);
  localparam bit SDP = (MODE == dpr_pkg::DPR_SDP9);
  localparam int SPACE = FULL ? `DPR_DATA_BITS : `DPR_HALF_DATA;
  localparam int DBASE = FULL ? 0 : HALF * `DPR_HALF_DATA;
  localparam int PBASE = DBASE / `DPR_PAR_RATIO;
  localparam int DB [2] = '{dbits(A_WIDTH), dbits(B_WIDTH)};
  localparam int PB [2] = '{pbits(A_WIDTH), pbits(B_WIDTH)};
  localparam int WORDS [2] = '{SPACE / dbits(A_WIDTH), SPACE / dbits(B_WIDTH)};
  localparam bit OREG [2] = '{A_OUT_REG, B_OUT_REG};
  localparam logic [`DPR_PORT_W-1:0] DMASK [2] = '{
    (36'h1 << (DB[0] + PB[0])) - 36'h1,
    (36'h1 << (DB[1] + PB[1])) - 36'h1
  };
  localparam dpr_pkg::dpr_wmode_t WMODE [2] = '{A_WMODE, B_WMODE};
  localparam bit RD_OK [2] = '{!SDP, 1'b1};
  localparam bit WR_OK [2] = '{1'b1, !SDP};
  localparam bit CFG_OK = legal_w(A_WIDTH) && legal_w(B_WIDTH) &&
    (FULL || SDP || (A_WIDTH <= `DPR_NARROW_MAX && B_WIDTH <= `DPR_NARROW_MAX));

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  logic mem_d [`DPR_DATA_BITS];
  logic mem_p [`DPR_PAR_BITS];
  dpr_pkg::dpr_state_t st_ff;
  dpr_pkg::dpr_state_t nxt_st;
  dpr_pkg::dpr_req_t [1:0] req_in;
  logic [1:0][`DPR_PORT_W-1:0] rd;
  logic [1:0][`DPR_PORT_W-1:0] mrg;
  logic [1:0] wr_go;
  logic [1:0] rd_go;
  int widx [2];

  assign req_in = {req_b, req_a};
  assign dout_a = st_ff.out[0];
  assign dout_b = st_ff.out[1];

  // ----------------------------------------
  // array read and write-data merge
  // ----------------------------------------
  always_comb begin
    rd = '0;
    mrg = '0;
    for (int p = 0; p < 2; p++) begin
      widx[p] = int'(st_ff.req[p].addr) % WORDS[p];
      wr_go[p] = st_ff.req[p].en && st_ff.req[p].we && WR_OK[p];
      rd_go[p] = st_ff.req[p].en && RD_OK[p];
      for (int i = 0; i < `DPR_MAX_DBITS; i++) begin
        if (i < DB[p]) begin
          rd[p][i] = mem_d[DBASE + widx[p] * DB[p] + i];
          mrg[p][i] = st_ff.req[p].be[i / 8] ? st_ff.req[p].din[i] : rd[p][i];
        end
      end
      for (int j = 0; j < `DPR_BE_W; j++) begin
        if (j < PB[p]) begin
          rd[p][DB[p] + j] = mem_p[PBASE + widx[p] * PB[p] + j];
          mrg[p][DB[p] + j] = st_ff.req[p].be[j] ? st_ff.req[p].din[DB[p] + j]
                                                 : rd[p][DB[p] + j];
        end
      end
    end
  end

  // port b is written last, so it wins a same-address clash
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (wr_go[p]) begin
        for (int i = 0; i < `DPR_MAX_DBITS; i++) begin
          if (i < DB[p] && st_ff.req[p].be[i / 8]) begin
            mem_d[DBASE + widx[p] * DB[p] + i] <= st_ff.req[p].din[i];
          end
        end
        for (int j = 0; j < `DPR_BE_W; j++) begin
          if (j < PB[p] && st_ff.req[p].be[j]) begin
            mem_p[PBASE + widx[p] * PB[p] + j] <= st_ff.req[p].din[DB[p] + j];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // output latch and pipeline
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    for (int p = 0; p < 2; p++) begin
      nxt_st.req[p] = req_in[p];
      if (rd_go[p]) begin
        if (!wr_go[p]) begin
          nxt_st.lat[p] = rd[p];
        end else begin
          case (WMODE[p])
            dpr_pkg::DPR_READ_FIRST: begin
              nxt_st.lat[p] = rd[p];
            end
            dpr_pkg::DPR_WRITE_FIRST: begin
              nxt_st.lat[p] = mrg[p];
            end
            default: begin
              nxt_st.lat[p] = st_ff.lat[p];
            end
          endcase
        end
      end
      nxt_st.out[p] = OREG[p] ? st_ff.lat[p] : nxt_st.lat[p];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking dpr_cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------
  // configuration checks
  // ----------------------------------------
  a_config_legal: assert property (CFG_OK)
    else $error("illegal width for memory mode");

  a_storage_size: assert property (SPACE * (FULL ? 1 : 2) == `DPR_DATA_BITS)
    else $error("storage does not span the full array");

  a_width_set: assert property (WORDS[0] * DB[0] == WORDS[1] * DB[1])
    else $error("port aspect ratios disagree on capacity");

  a_half_span: assert property (DBASE + SPACE <= `DPR_DATA_BITS)
    else $error("half memory runs past the array");

  a_par_ratio: assert property (PB[0] == 0 || PB[0] * `DPR_PAR_RATIO == DB[0])
    else $error("parity bits do not match data bytes");

  a_sdp_no_write: assert property (!(SDP && wr_go[1]))
    else $error("read port of simple dual-port mode wrote");

  a_sdp_no_read: assert property (!(SDP && rd_go[0]))
    else $error("write port of simple dual-port mode read");

  // ----------------------------------------
  // per-port checks
  // ----------------------------------------

  for (genvar g = 0; g < 2; g++) begin : g_chk
    a_idle_hold: assert property (!st_ff.req[g].en |=> $stable(st_ff.lat[g]))
      else $error("read data changed without an operation");
    a_lat_direct: assert property (
      !OREG[g] && RD_OK[g] && req_in[g].en && !req_in[g].we
      |-> ##2 st_ff.out[g] == $past(rd[g]))
      else $error("unpipelined read latency wrong");
    a_lat_piped: assert property (
      OREG[g] && RD_OK[g] && req_in[g].en && !req_in[g].we
      |-> ##3 st_ff.out[g] == $past(rd[g], 2))
      else $error("pipelined read latency wrong");
    a_read_first: assert property (
      rd_go[g] && wr_go[g] && WMODE[g] == dpr_pkg::DPR_READ_FIRST
      |=> st_ff.lat[g] == $past(rd[g]))
      else $error("read-first write did not show old data");
    a_write_first: assert property (
      rd_go[g] && wr_go[g] && WMODE[g] == dpr_pkg::DPR_WRITE_FIRST
      |=> st_ff.lat[g] == $past(mrg[g]))
      else $error("write-first write did not show new data");
    a_no_change: assert property (
      wr_go[g] && WMODE[g] == dpr_pkg::DPR_NO_CHANGE |=> $stable(st_ff.lat[g]))
      else $error("no-change write altered read data");
    a_sdp_silent: assert property (!RD_OK[g] |=> $stable(st_ff.lat[g]))
      else $error("write-only port produced read data");
    a_byte_keep: assert property (
      wr_go[g] && !st_ff.req[g].be[1] && DB[g] >= 16 && !wr_go[1 - g]
      ##1 st_ff.req[g].addr == $past(st_ff.req[g].addr)
      |-> rd[g][15:8] == $past(rd[g][15:8]))
      else $error("disabled byte was overwritten");

    a_par_keep: assert property (
      wr_go[g] && !st_ff.req[g].be[0] && PB[g] > 0 && !wr_go[1 - g]
      ##1 st_ff.req[g].addr == $past(st_ff.req[g].addr)
      |-> rd[g][DB[g]] == $past(rd[g][DB[g]]))
      else $error("disabled parity bit was overwritten");

    a_write_lands: assert property (
      wr_go[g] && st_ff.req[g].be == 4'hF && !wr_go[1 - g]
      ##1 st_ff.req[g].addr == $past(st_ff.req[g].addr)
      |-> ((rd[g] ^ $past(st_ff.req[g].din)) & DMASK[g]) == '0)
      else $error("written word not found on read back");

    a_read_keeps: assert property (
      rd_go[g] && !wr_go[g] && !wr_go[1 - g]
      ##1 st_ff.req[g].addr == $past(st_ff.req[g].addr)
      |-> rd[g] == $past(rd[g]))
      else $error("read disturbed the stored word");

    // ----------------------------------------
    // reset, capture and output stage
    // ----------------------------------------
    a_req_capture: assert property (
      !$past(reset) |-> st_ff.req[g] == $past(req_in[g]))
      else $error("request not captured at the clock edge");

    a_idle_nowrite: assert property (
      !st_ff.req[g].en |-> !wr_go[g] && !rd_go[g])
      else $error("array accessed without an operation");

    a_reset_clear: assert property (
      disable iff (1'b0) reset |=> st_ff.lat[g] == '0 && st_ff.out[g] == '0)
      else $error("read data not cleared by reset");

    a_idle_out: assert property (
      !st_ff.req[g].en && !$past(st_ff.req[g].en) |=> $stable(st_ff.out[g]))
      else $error("output changed across idle cycles");

    a_out_piped: assert property (OREG[g] |=> st_ff.out[g] == $past(st_ff.lat[g]))
      else $error("pipeline register did not follow the latch");

    a_out_direct: assert property (!OREG[g] |-> st_ff.out[g] == st_ff.lat[g])
      else $error("output differs from latch without pipeline");

    a_pad_zero: assert property ((st_ff.out[g] & ~DMASK[g]) == '0)
      else $error("unused read data bits not zero");

    a_wf_byte0: assert property (
      rd_go[g] && wr_go[g] && WMODE[g] == dpr_pkg::DPR_WRITE_FIRST && DB[g] >= 8
      |=> st_ff.lat[g][7:0] == ($past(st_ff.req[g].be[0]) ? $past(st_ff.req[g].din[7:0])
                                                            : $past(rd[g][7:0])))
      else $error("write-first byte 0 wrong");

    // ----------------------------------------
    // coverage
    // ----------------------------------------
    c_read: cover property (rd_go[g] && !wr_go[g]);
    c_write: cover property (wr_go[g] ##1 rd_go[g] && !st_ff.req[g].we);
    c_byte_mask: cover property (wr_go[g] && st_ff.req[g].be != 4'hF);
    c_idle_run: cover property (rd_go[g] ##1 !st_ff.req[g].en ##1 !st_ff.req[g].en);
  end
  c_both_write: cover property (wr_go[0] && wr_go[1]);

endmodule // dpr_block_ram

//--- tb/dpr_fabric_user.sv
`timescale 1ns/1ps
// ----------------------------------------
// fabric requester for one port
// ----------------------------------------
module dpr_fabric_user (
  // clock
  input wire logic clk,
  // request toward the memory
  output dpr_pkg::dpr_req_t req
);
  initial req = '0;
  // one request per cycle, fields scrambled while idle
  task automatic put(input logic en, input logic we, input logic [3:0] be,
                     input logic [13:0] addr, input logic [35:0] din);
    @(posedge clk);
    #1;
    req.en = en;
    req.we = en & we;
    req.be = en ? be : ~req.be;
    req.addr = en ? addr : ~req.addr;
    req.din = en ? din : ~req.din;
  endtask
endmodule // dpr_fabric_user

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk;
  logic reset;
  dpr_pkg::dpr_req_t req_a;
  dpr_pkg::dpr_req_t req_b;
  logic [35:0] dout_a;
  logic [35:0] dout_b;
  logic [35:0] held_a, held_b, pa, pb1, pb2;
  logic va, vb1, vb2;
  logic mem [0:16383];
  logic par [0:2047];
  int mismatches;
  int check_count;

  dpr_block_ram #(.A_WIDTH(36), .B_WIDTH(9), .A_WMODE(dpr_pkg::DPR_WRITE_FIRST),
    .B_WMODE(dpr_pkg::DPR_NO_CHANGE), .B_OUT_REG(1'b1)) dut (.clk(clk), .reset(reset),
    .req_a(req_a), .dout_a(dout_a), .req_b(req_b), .dout_b(dout_b));
  dpr_fabric_user ua (.clk(clk), .req(req_a));
  dpr_fabric_user ub (.clk(clk), .req(req_b));

  // ----------------------------------------
  // reference memory, flat bit order
  // ----------------------------------------
  function automatic logic [35:0] access(dpr_pkg::dpr_req_t r, int db, int pb);
    logic [35:0] w;
    int base;
    w = '0;
    base = (r.addr % (16384 / db)) * db;
    for (int i = 0; i < db; i++) begin
      if (r.we && r.be[i / 8]) mem[base + i] = r.din[i];
      w[i] = mem[base + i];
    end
    for (int k = 0; k < pb; k++) begin
      if (r.we && r.be[k]) par[base / 8 + k] = r.din[db + k];
      w[db + k] = par[base / 8 + k];
    end
    return w;
  endfunction

  always @(posedge clk) begin
    if (reset) begin
      held_a = '0;
      held_b = '0;
      va = 1'b0;
      vb1 = 1'b0;
      vb2 = 1'b0;
    end else begin
      if (va) held_a = pa;
      if (vb2) held_b = pb2;
      vb2 = vb1;
      pb2 = pb1;
      va = req_a.en;
      if (req_a.en) pa = access(req_a, 32, 4);
      vb1 = req_b.en && !req_b.we;
      if (req_b.en) pb1 = access(req_b, 8, 1);
    end
  end

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(negedge clk) begin
    if (!reset) begin
      cmp(dout_a, held_a);
      cmp(dout_b, held_b);
    end
  end

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  function automatic logic [35:0] r36();
    logic [63:0] v;
    v = {$urandom(), $urandom()};
    return v[35:0];
  endfunction

  // sel 0: port a only, 1: both apart, 2: port b only
  task automatic run(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      logic [13:0] aa;
      logic [13:0] ab;
      aa = 14'($urandom());
      ab = 14'($urandom());
      if (sel == 1) begin
        aa[8] = 1'b0;
        ab[10] = 1'b1;
      end
      fork
        ua.put(sel != 2, 1'($urandom()), 4'($urandom()), aa, r36());
        ub.put(sel != 0, 1'($urandom()), 4'($urandom()), ab, r36());
      join
    end
    $display("test %0d done", sel);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    mismatches = 0;
    check_count = 0;
    reset = 1'b1;
    void'($urandom(32'hC9889564));
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 512; i++) ua.put(1'b1, 1'b1, 4'hF, 14'(i), r36());
    $display("test fill done");
    run(0, 300);
    run(1, 300);
    run(2, 300);
    repeat (4) ua.put(1'b0, 1'b0, 4'h0, 14'h0, 36'h0);
    close_out();
  end

  initial begin
    #50000;
    mismatches++;
    close_out();
  end
endmodule // tb
